// ---- design/mcct_pkg.sv ----
// Package: constants and types for the match/capture counter-timer
package mcct_pkg;
  localparam int unsigned WIDE_BITS   = 32;
  localparam int unsigned NARROW_BITS = 16;
  localparam int unsigned NUM_MATCH   = 4;
  localparam int unsigned CLK_HZ      = 40000000;
  // Field positions of the per-match 3-bit control field
  localparam int unsigned MCTL_IRQ_BIT   = 0;
  localparam int unsigned MCTL_RESET_BIT = 1;
  localparam int unsigned MCTL_STOP_BIT  = 2;
  localparam int unsigned MCTL_W         = 3;
  // External match output actions
  typedef enum logic [1:0] {
    MCCT_EXT_NONE   = 2'h0,
    MCCT_EXT_LOW    = 2'h1,
    MCCT_EXT_HIGH   = 2'h2,
    MCCT_EXT_TOGGLE = 2'h3
  } mcct_ext_e;
  // Edge selection bits (capture, count and clear edges) and edge detector reset level
  localparam int unsigned CAP_RISE_BIT = 0;
  localparam int unsigned CAP_FALL_BIT = 1;
  localparam logic        RESET_LEVEL  = 1'h0;
endpackage

// ---- design/mcct_edge.sv ----
// Edge detector for capture and count inputs
`timescale 1ns/1ps
`default_nettype none
module mcct_edge (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic sig_in,
  output logic      rise,
  output logic      fall,
  output logic      level
);
  logic prev_q;
  logic prev_d;

  always_comb begin
    prev_d = sig_in;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= mcct_pkg::RESET_LEVEL;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise  = sig_in & ~prev_q;
  assign fall  = ~sig_in & prev_q;
  assign level = prev_q;
endmodule
`default_nettype wire

// ---- design/mcct_top.sv ----
// Match/capture counter-timer, 32 or 16 bits wide
`timescale 1ns/1ps
`default_nettype none
module mcct_top #(
  parameter int unsigned WIDTH = mcct_pkg::WIDE_BITS
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  input  wire logic                         enable,
  input  wire logic                         sw_reset,
  input  wire logic                         counter_mode,
  input  wire logic [1:0]                   count_edge_sel,
  input  wire logic                         count_in,
  input  wire logic [WIDTH-1:0]             prescale,
  input  wire logic [4*WIDTH-1:0]           match_val,
  input  wire logic [4*mcct_pkg::MCTL_W-1:0] match_ctl,
  input  wire logic [7:0]                   ext_action,
  input  wire logic [3:0]                   pwm_en,
  input  wire logic                         cap_in,
  input  wire logic [1:0]                   cap_edge_sel,
  input  wire logic                         cap_irq_en,
  input  wire logic [1:0]                   cap_clear_sel,
  input  wire logic [3:0]                   irq_clear,
  input  wire logic                         cap_irq_clear,
  output logic      [WIDTH-1:0]             count_q,
  output logic      [WIDTH-1:0]             prescale_count_q,
  output logic      [WIDTH-1:0]             capture_q,
  output logic                              running_q,
  output logic      [3:0]                   match_out_q,
  output logic      [3:0]                   match_irq_q,
  output logic                              cap_irq_q,
  output logic      [3:0]                   adc_match_trig_q,
  output logic                              adc_cap_trig_q
);
  if (WIDTH != mcct_pkg::WIDE_BITS && WIDTH != mcct_pkg::NARROW_BITS) begin : g_bad_width
    $error("WIDTH must be 32 or 16");
  end

  logic cap_rise;
  logic cap_fall;
  logic cap_lvl;
  logic cnt_rise;
  logic cnt_fall;

  mcct_edge u_cap_edge (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .sig_in  (cap_in),
    .rise    (cap_rise),
    .fall    (cap_fall),
    .level   (cap_lvl)
  );

  mcct_edge u_cnt_edge (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .sig_in  (count_in),
    .rise    (cnt_rise),
    .fall    (cnt_fall),
    .level   ()
  );

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = (sel[mcct_pkg::CAP_RISE_BIT] & r) | (sel[mcct_pkg::CAP_FALL_BIT] & f);
  endfunction

  logic             tick;
  logic             cap_evt;
  logic             cap_clr;
  logic [3:0]       hit;
  logic [WIDTH-1:0] count_d;
  logic [WIDTH-1:0] prescale_count_d;
  logic [WIDTH-1:0] capture_d;
  logic             running_d;
  logic [3:0]       match_out_d;
  logic [3:0]       match_irq_d;
  logic             cap_irq_d;
  logic [3:0]       adc_match_trig_d;
  logic             adc_cap_trig_d;
  logic             any_reset;
  logic             any_stop;

  always_comb begin
    tick = 1'h0;
    prescale_count_d = prescale_count_q;
    cap_evt = edge_hit(cap_edge_sel, cap_rise, cap_fall);
    cap_clr = edge_hit(cap_clear_sel, cap_rise, cap_fall);
    if (running_q) begin
      if (counter_mode) begin
        tick = edge_hit(count_edge_sel, cnt_rise, cnt_fall);
      end else if (prescale_count_q >= prescale) begin
        prescale_count_d = '0;
        tick = 1'h1;
      end else begin
        prescale_count_d = prescale_count_q + WIDTH'(1);
      end
    end
    if (sw_reset || cap_clr) begin
      prescale_count_d = '0;
    end
  end

  // Matches compare continuously, acting only on a counter tick
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_match
      assign hit[gi] = tick && (count_q == match_val[gi*WIDTH +: WIDTH]);
    end
  endgenerate

  always_comb begin
    any_reset = 1'h0;
    any_stop = 1'h0;
    match_irq_d = match_irq_q & ~irq_clear;
    match_out_d = match_out_q;
    for (int i = 0; i < 4; i++) begin
      if (hit[i]) begin
        if (match_ctl[i*mcct_pkg::MCTL_W + mcct_pkg::MCTL_IRQ_BIT]) begin
          match_irq_d[i] = 1'h1;  // set wins over clear
        end
        any_reset = any_reset | match_ctl[i*mcct_pkg::MCTL_W + mcct_pkg::MCTL_RESET_BIT];
        any_stop = any_stop | match_ctl[i*mcct_pkg::MCTL_W + mcct_pkg::MCTL_STOP_BIT];
        unique case (mcct_pkg::mcct_ext_e'(ext_action[2*i +: 2]))
          mcct_pkg::MCCT_EXT_NONE:   match_out_d[i] = match_out_q[i];
          mcct_pkg::MCCT_EXT_LOW:    match_out_d[i] = 1'h0;
          mcct_pkg::MCCT_EXT_HIGH:   match_out_d[i] = 1'h1;
          mcct_pkg::MCCT_EXT_TOGGLE: match_out_d[i] = ~match_out_q[i];
        endcase
      end
      if (pwm_en[i]) begin
        // High once count reaches match, low after the period reset
        match_out_d[i] = (count_d >= match_val[i*WIDTH +: WIDTH]);
      end
    end
  end

  always_comb begin
    count_d = count_q;
    running_d = running_q | enable;
    if (!enable) begin
      running_d = 1'h0;
    end
    if (tick) begin
      if (any_reset) begin
        count_d = '0;
      end else begin
        count_d = count_q + WIDTH'(1);
      end
      if (any_stop) begin
        running_d = 1'h0;
      end
    end
    if (sw_reset || cap_clr) begin
      count_d = '0;
    end
    capture_d = cap_evt ? count_q : capture_q;
    cap_irq_d = (cap_irq_q & ~cap_irq_clear) | (cap_evt & cap_irq_en);
    // Match trigger lags its pin by one cycle, capture trigger lags cap_in by two; both are clean register copies
    adc_match_trig_d = match_out_q;
    adc_cap_trig_d = cap_lvl;
  end

  // Halt on match holds until software drops and re-raises enable
  logic stopped_q;
  logic stopped_d;
  always_comb begin
    stopped_d = stopped_q;
    if (!enable) begin
      stopped_d = 1'h0;
    end else if (tick && any_stop) begin
      stopped_d = 1'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      prescale_count_q <= '0;
      capture_q <= '0;
      running_q <= 1'h0;
      match_out_q <= 4'h0;
      match_irq_q <= 4'h0;
      cap_irq_q <= 1'h0;
      adc_match_trig_q <= 4'h0;
      adc_cap_trig_q <= 1'h0;
      stopped_q <= 1'h0;
    end else begin
      count_q <= count_d;
      prescale_count_q <= prescale_count_d;
      capture_q <= capture_d;
      running_q <= running_d & ~stopped_d;
      match_out_q <= match_out_d;
      match_irq_q <= match_irq_d;
      cap_irq_q <= cap_irq_d;
      adc_match_trig_q <= adc_match_trig_d;
      adc_cap_trig_q <= adc_cap_trig_d;
      stopped_q <= stopped_d;
    end
  end

  property p_presc_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
      (running_q && !counter_mode && !sw_reset && !cap_clr && prescale_count_q >= prescale)
      |=> (prescale_count_q == '0);
  endproperty
  a_presc_wrap: assert property (p_presc_wrap) else $error("prescaler did not wrap");

  property p_tick_inc;
    @(posedge sys_clk) disable iff (!rst_n)
      (tick && !any_reset && !sw_reset && !cap_clr) |=> (count_q == $past(count_q) + WIDTH'(1));
  endproperty
  a_tick_inc: assert property (p_tick_inc) else $error("count did not advance");

  property p_match_reset;
    @(posedge sys_clk) disable iff (!rst_n)
      (tick && any_reset) |=> (count_q == '0);
  endproperty
  a_match_reset: assert property (p_match_reset) else $error("match reset failed");

  property p_match_stop;
    @(posedge sys_clk) disable iff (!rst_n)
      (tick && any_stop) |=> !running_q;
  endproperty
  a_match_stop: assert property (p_match_stop) else $error("match stop failed");

  property p_match_irq;
    @(posedge sys_clk) disable iff (!rst_n)
      (hit[0] && match_ctl[mcct_pkg::MCTL_IRQ_BIT]) |=> match_irq_q[0];
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("match irq missing");

  property p_capture;
    @(posedge sys_clk) disable iff (!rst_n)
      cap_evt |=> (capture_q == $past(count_q));
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_cap_irq;
    @(posedge sys_clk) disable iff (!rst_n)
      (cap_evt && cap_irq_en) |=> cap_irq_q;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture irq missing");

  property p_cap_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      cap_clr |=> (count_q == '0 && prescale_count_q == '0);
  endproperty
  a_cap_clear: assert property (p_cap_clear) else $error("capture clear failed");

  property p_toggle;
    @(posedge sys_clk) disable iff (!rst_n)
      (hit[1] && !pwm_en[1] && ext_action[3:2] == 2'h3) |=> (match_out_q[1] != $past(match_out_q[1]));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle failed");

  property p_adc_trig;
    @(posedge sys_clk) disable iff (!rst_n)
      ##1 (adc_match_trig_q == $past(match_out_q));
  endproperty
  a_adc_trig: assert property (p_adc_trig) else $error("adc trigger mismatch");

  c_match_reset: cover property (@(posedge sys_clk) disable iff (!rst_n) tick && any_reset);
  c_capture: cover property (@(posedge sys_clk) disable iff (!rst_n) cap_evt);
  c_stop: cover property (@(posedge sys_clk) disable iff (!rst_n) tick && any_stop);
  c_pwm: cover property (@(posedge sys_clk) disable iff (!rst_n) pwm_en[2] && $rose(match_out_q[2]));
  c_toggle: cover property (@(posedge sys_clk) disable iff (!rst_n) hit[0] && ext_action[1:0] == 2'h3);

  property p_cnt_tick;
    @(posedge sys_clk) disable iff (!rst_n)
      (running_q && counter_mode && !sw_reset && !cap_clr && !any_reset
        && edge_hit(count_edge_sel, cnt_rise, cnt_fall)) |=> (count_q == $past(count_q) + WIDTH'(1));
  endproperty
  a_cnt_tick: assert property (p_cnt_tick) else $error("event count did not advance");

  property p_pwm_level;
    @(posedge sys_clk) disable iff (!rst_n)
      pwm_en[2] |=> (match_out_q[2] == (count_q >= $past(match_val[2*WIDTH +: WIDTH])));
  endproperty
  a_pwm_level: assert property (p_pwm_level) else $error("pwm level wrong");

  property p_cap_trig;
    @(posedge sys_clk) disable iff (!rst_n)
      ##2 (adc_cap_trig_q == $past(cap_in, 2));
  endproperty
  a_cap_trig: assert property (p_cap_trig) else $error("capture trigger mismatch");

  property p_match_low;
    @(posedge sys_clk) disable iff (!rst_n)
      (hit[1] && !pwm_en[1] && ext_action[3:2] == 2'h1) |=> !match_out_q[1];
  endproperty
  a_match_low: assert property (p_match_low) else $error("set low failed");
endmodule
`default_nettype wire

// ---- verification/mcct_pin_model.sv ----
// Pin-side model: drives capture and count pins, watches match output 0
`timescale 1ns/1ps
`default_nettype none
module mcct_pin_model (
  input  wire logic sys_clk,
  input  wire logic match_out,
  output logic      cap_pin,
  output logic      cnt_pin
);
  logic prev_q = 1'h0;
  int   n_tog  = 0;
  initial begin
    cap_pin = 1'h0;
    cnt_pin = 1'h0;
  end
  always @(posedge sys_clk) begin
    prev_q <= match_out;
    if (match_out !== prev_q) n_tog++;
  end
  task automatic cap_level(input logic v);
    @(negedge sys_clk) cap_pin = v;
  endtask
  // Two-cycle pulses so the edge detector never misses one
  task automatic cnt_pulses(input int n);
    repeat (n) begin
      @(negedge sys_clk) cnt_pin = 1'h1;
      repeat (2) @(negedge sys_clk);
      cnt_pin = 1'h0;
      repeat (2) @(negedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/match_capture_counter_timer_bench.sv ----
// Bench for the match/capture counter-timer, narrow build
`timescale 1ns/1ps
`default_nettype none
module match_capture_counter_timer_bench;
  localparam int W = 16;
  logic sys_clk, rst_n, enable, sw_reset, counter_mode, cap_irq_en, cap_irq_clear;
  logic [1:0] count_edge_sel, cap_edge_sel, cap_clear_sel;
  logic [W-1:0] prescale, count_q, prescale_count_q, capture_q;
  logic [4*W-1:0] match_val;
  logic [11:0] match_ctl;
  logic [7:0] ext_action;
  logic [3:0] pwm_en, irq_clear, match_out_q, match_irq_q, adc_match_trig_q;
  logic running_q, cap_irq_q, adc_cap_trig_q, cap_pin, cnt_pin;
  int failures = 0;
  int n_tests = 0;
  int k;
  mcct_top #(.WIDTH(W)) DUT (.sys_clk, .rst_n, .enable, .sw_reset, .counter_mode,
    .count_edge_sel, .count_in(cnt_pin), .prescale, .match_val, .match_ctl, .ext_action,
    .pwm_en, .cap_in(cap_pin), .cap_edge_sel, .cap_irq_en, .cap_clear_sel, .irq_clear,
    .cap_irq_clear, .count_q, .prescale_count_q, .capture_q, .running_q, .match_out_q,
    .match_irq_q, .cap_irq_q, .adc_match_trig_q, .adc_cap_trig_q);
  mcct_pin_model pins (.sys_clk, .match_out(match_out_q[0]), .cap_pin, .cnt_pin);
  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    $display("tests %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Bounded wait; a hang ends the run as a failure
  task automatic wait_count(input logic [W-1:0] v);
    int t;
    t = 0;
    while (count_q !== v && t < 200) begin
      cyc(1);
      t++;
    end
    if (t == 200) begin
      failures++;
      final_report();
    end
  endtask
  task automatic restart();
    enable = 1'h0;
    sw_reset = 1'h1;
    cyc(2);
    sw_reset = 1'h0;
  endtask
  initial begin
    {rst_n, enable, sw_reset, counter_mode, cap_irq_en, cap_irq_clear} = '0;
    {count_edge_sel, cap_edge_sel, cap_clear_sel, pwm_en, irq_clear} = '0;
    prescale = '0;
    match_val = {16'h0002, 16'h0003, 16'h0003, 16'h0005};
    match_ctl = '0;
    ext_action = '0;
    cyc(6);
    rst_n = 1'h1;
    cyc(1);
    chk(count_q, 16'h0000);
    chk({running_q, match_irq_q, cap_irq_q}, 16'h0000);
    prescale = 16'h0003;
    enable = 1'h1;
    wait_count(16'h0001);
    k = 0;
    while (count_q === 16'h0001 && k < 20) begin
      cyc(1);
      k++;
    end
    chk(k, 4);
    restart();
    prescale = '0;
    match_ctl = 12'h00B;
    ext_action = 8'h0B;
    pins.n_tog = 0;
    enable = 1'h1;
    k = 0;
    repeat (60) begin
      cyc(1);
      if (count_q > 16'h0005) k++;
    end
    chk(k, 0);
    chk(pins.n_tog >= 9 && pins.n_tog <= 11, 1);
    chk(match_irq_q, 16'h0003);
    chk(match_out_q[3:1], 16'h0001);
    ext_action = 8'h07;
    cyc(20);
    chk(match_out_q[1], 16'h0000);
    enable = 1'h0;
    cyc(2);
    irq_clear = 4'hF;
    cyc(1);
    irq_clear = 4'h0;
    chk(match_irq_q, 16'h0000);
    chk(adc_match_trig_q, 16'h0001);
    restart();
    match_val[W-1:0] = 16'h0007;
    match_ctl = 12'h004;
    ext_action = '0;
    enable = 1'h1;
    wait_count(16'h0007);
    cyc(5);
    // Halt acts as the count leaves the match value
    chk(count_q, 16'h0008);
    chk(running_q, 16'h0000);
    cap_edge_sel = 2'h1;
    cap_clear_sel = 2'h2;
    cap_irq_en = 1'h1;
    pins.cap_level(1'h1);
    cyc(3);
    chk(adc_cap_trig_q, 16'h0001);
    chk(capture_q, 16'h0008);
    chk(cap_irq_q, 16'h0001);
    chk(count_q, 16'h0008);
    cap_irq_clear = 1'h1;
    cyc(1);
    cap_irq_clear = 1'h0;
    chk(cap_irq_q, 16'h0000);
    pins.cap_level(1'h0);
    cyc(3);
    chk(count_q, 16'h0000);
    chk(prescale_count_q, 16'h0000);
    chk(capture_q, 16'h0008);
    restart();
    match_ctl = '0;
    counter_mode = 1'h1;
    count_edge_sel = 2'h1;
    enable = 1'h1;
    pins.cnt_pulses(5);
    cyc(4);
    chk(count_q, 16'h0005);
    restart();
    counter_mode = 1'h0;
    match_val = {16'h0002, 16'h0004, 16'h0003, 16'h0009};
    match_ctl = 12'h002;
    pwm_en = 4'h4;
    enable = 1'h1;
    k = 0;
    repeat (30) begin
      cyc(1);
      if (match_out_q[2] !== (count_q >= 16'h0004)) k++;
    end
    chk(k, 0);
    final_report();
  end
endmodule
`default_nettype wire
